//--- bod_decoder.sv
// Purpose: Opcode byte decoder with call and return stack handling
// Assumes: Avalon-MM slave, 32-bit data, byte addresses, waitrequest
// Notes: Writing the instruction register decodes and executes flow ops
//
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module bod_decoder (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest
);

    ////////////////////////////////////////////////////////////////////
    // Decode function shared by readback and execution
    function automatic bod_pkg::bod_dec_s decode(input logic [7:0] op);
        bod_pkg::bod_dec_s d;
        logic [3:0] row;
        logic [3:0] col;
        row = op[7:4];
        col = op[3:0];
        d.op_class = bod_pkg::BOD_OTHER;
        d.working_register_index = op[2:0];
        d.pointer_sel = op[0];
        d.expander_port_select = 3'(bod_pkg::BOD_EXP_PORT_BASE + {2'h0, op[1:0]});
        d.page = op[7:5];
        d.acc_bit = op[7:5];
        d.two_byte = 1'b0;
        case (op)
            // Unassigned codes become harmless single-cycle ops
            8'h06, 8'h0B, 8'h22, 8'h33, 8'h38, 8'h3B, 8'h63, 8'h66,
            8'h73, 8'h82, 8'h87, 8'h8B, 8'h9B, 8'hA2, 8'hA6, 8'hB7,
            8'hC0, 8'hC2, 8'hC3, 8'hD6, 8'hE0, 8'hE1, 8'hE2, 8'hF3: begin
                d.op_class = bod_pkg::BOD_BLANK;
            end
            8'h00: d.op_class = bod_pkg::BOD_NOP;
            8'h01: d.op_class = bod_pkg::BOD_HALT;
            8'hC1: d.op_class = bod_pkg::BOD_STOP;
            8'hC5: d.op_class = bod_pkg::BOD_SELECT_REGISTER_BANK_ZERO;
            8'hC6: begin
                d.op_class = bod_pkg::BOD_ACC_ZERO_BRANCH;
                d.two_byte = 1'b1;
            end
            8'h42: d.op_class = bod_pkg::BOD_TIMER_READ;
            8'h62: d.op_class = bod_pkg::BOD_TIMER_LOAD;
            8'h45: d.op_class = bod_pkg::BOD_EVENT_COUNT_START;
            8'h55: d.op_class = bod_pkg::BOD_TIMER_RUN_START;
            8'h65: d.op_class = bod_pkg::BOD_TIMER_HALT;
            8'h75: d.op_class = bod_pkg::BOD_T0_CLOCK_EN;
            8'hA3: d.op_class = bod_pkg::BOD_PAGE_TABLE_READ;
            8'hE3: d.op_class = bod_pkg::BOD_PAGE3_TABLE_READ;
            8'hB3: d.op_class = bod_pkg::BOD_INDIRECT_JUMP;
            8'h83: d.op_class = bod_pkg::BOD_RETURN;
            8'h93: d.op_class = bod_pkg::BOD_RETURN_RESTORE;
            8'h86: begin
                d.op_class = bod_pkg::BOD_INT_LOW_BRANCH;
                d.two_byte = 1'b1;
            end
            8'h80, 8'h81: d.op_class = bod_pkg::BOD_EXT_READ;
            8'h90, 8'h91: d.op_class = bod_pkg::BOD_EXT_WRITE;
            8'h10, 8'h11: d.op_class = bod_pkg::BOD_IND_INC;
            8'h02: d.op_class = bod_pkg::BOD_BUS_OUT;
            8'h08: d.op_class = bod_pkg::BOD_BUS_STROBE_IN;
            8'h09: d.op_class = bod_pkg::BOD_P1_IN;
            8'h0A: d.op_class = bod_pkg::BOD_P2_IN;
            8'h39: d.op_class = bod_pkg::BOD_P1_OUT;
            8'h3A: d.op_class = bod_pkg::BOD_P2_OUT;
            default: begin
                if (col[3]) begin
                    // Register column half, with expander ports in C-F
                    case (row)
                        4'h1: d.op_class = bod_pkg::BOD_REG_INC;
                        4'hC: d.op_class = bod_pkg::BOD_REG_DEC;
                        4'h2: d.op_class = bod_pkg::BOD_REG_XCH;
                        4'h4: d.op_class = bod_pkg::BOD_REG_OR;
                        4'h5: d.op_class = bod_pkg::BOD_REG_AND;
                        4'hD: d.op_class = bod_pkg::BOD_REG_XOR;
                        4'h6: d.op_class = bod_pkg::BOD_REG_ADD;
                        4'h7: d.op_class = bod_pkg::BOD_REG_ADD_WITH_CARRY;
                        4'hA: d.op_class = bod_pkg::BOD_REG_FROM_ACC;
                        4'hB: begin
                            d.op_class = bod_pkg::BOD_REG_LOAD_IMM;
                            d.two_byte = 1'b1;
                        end
                        4'hF: d.op_class = bod_pkg::BOD_REG_TO_ACC;
                        4'hE: begin
                            d.op_class = bod_pkg::BOD_DECREMENT_BRANCH_NONZERO;
                            d.two_byte = 1'b1;
                        end
                        4'h0: begin
                            if (col[2]) d.op_class = bod_pkg::BOD_EXP_READ;
                        end
                        4'h3: begin
                            if (col[2]) d.op_class = bod_pkg::BOD_EXP_WRITE;
                        end
                        4'h8: begin
                            if (col[2]) d.op_class = bod_pkg::BOD_EXP_OR;
                            else d.two_byte = 1'b1;
                        end
                        4'h9: begin
                            if (col[2]) d.op_class = bod_pkg::BOD_EXP_AND;
                            else d.two_byte = 1'b1;
                        end
                        default: d.op_class = bod_pkg::BOD_OTHER;
                    endcase
                end else if (col == 4'h4) begin
                    // Row parity picks jump or call
                    d.op_class = row[0] ? bod_pkg::BOD_CALL : bod_pkg::BOD_JUMP;
                    d.two_byte = 1'b1;
                end else if (col == 4'h2 && row[0]) begin
                    d.op_class = bod_pkg::BOD_ACC_BIT_BRANCH;
                    d.two_byte = 1'b1;
                end else if (col == 4'h7) begin
                    case (row)
                        4'h0: d.op_class = bod_pkg::BOD_ACC_DEC;
                        4'h1: d.op_class = bod_pkg::BOD_ACC_INC;
                        4'h2: d.op_class = bod_pkg::BOD_ACC_CLR;
                        4'h3: d.op_class = bod_pkg::BOD_ACC_CPL;
                        4'h4: d.op_class = bod_pkg::BOD_ACC_SWAP;
                        4'h5: d.op_class = bod_pkg::BOD_ACC_DA;
                        4'h6: d.op_class = bod_pkg::BOD_ACC_RRC;
                        4'h7: d.op_class = bod_pkg::BOD_ACC_RR;
                        4'hE: d.op_class = bod_pkg::BOD_ACC_RL;
                        4'hF: d.op_class = bod_pkg::BOD_ACC_RLC;
                        default: d.op_class = bod_pkg::BOD_OTHER;
                    endcase
                end else begin
                    // Remaining documented codes; immediates and branches take a byte
                    d.two_byte = (col == 4'h3) || (col == 4'h6);
                end
            end
        endcase
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // State
    logic waitrequest_r;
    logic [31:0] readdata_r;
    logic [7:0] opcode_r;
    logic [7:0] operand_r;
    logic [11:0] pc_r;
    logic [2:0] stack_pointer_r;
    logic [7:0] program_status_word_r;
    logic memory_bank_flag_r;

    bod_stack_if stk ();
    bod_stack u_stack (
        .clock(clock),
        .rst_n(rst_n),
        .stk(stk)
    );

    logic req_take;
    logic wr_go;
    bod_pkg::bod_dec_s now_dec;
    bod_pkg::bod_dec_s exe_dec;
    logic exe_instr;
    logic do_call;
    logic do_jump;
    logic do_ret;
    logic do_return_restore_status;
    logic [2:0] sp_dec;
    logic [31:0] dec_word;

    // Request first seen; answer follows one cycle later
    assign req_take = (read || write) && waitrequest_r;
    assign wr_go = write && !waitrequest_r;
    assign now_dec = decode(opcode_r);
    assign exe_dec = decode(writedata[7:0]);
    assign exe_instr = wr_go && (address == bod_pkg::BOD_OFF_INSTR) && byteenable[0];
    assign do_call = exe_instr && (exe_dec.op_class == bod_pkg::BOD_CALL);
    assign do_jump = exe_instr && (exe_dec.op_class == bod_pkg::BOD_JUMP);
    assign do_ret = exe_instr && (exe_dec.op_class == bod_pkg::BOD_RETURN);
    assign do_return_restore_status = exe_instr && (exe_dec.op_class == bod_pkg::BOD_RETURN_RESTORE);
    assign sp_dec = stack_pointer_r - 3'h1;

    // Stack traffic: push at pointer, peek just below it
    assign stk.push = do_call;
    assign stk.wr_idx = stack_pointer_r;
    assign stk.wr_data = {program_status_word_r[7:bod_pkg::BOD_PSW_UP_LSB],
                          memory_bank_flag_r, pc_r};
    assign stk.rd_idx = sp_dec;

    // Decode readback word
    always_comb begin
        dec_word = '0;
        dec_word[bod_pkg::BOD_DEC_CLASS_LSB +: 6] = now_dec.op_class;
        dec_word[bod_pkg::BOD_DEC_REG_LSB +: 3] = now_dec.working_register_index;
        dec_word[bod_pkg::BOD_DEC_PTR_BIT] = now_dec.pointer_sel;
        dec_word[bod_pkg::BOD_DEC_PORT_LSB +: 3] = now_dec.expander_port_select;
        dec_word[bod_pkg::BOD_DEC_PAGE_LSB +: 3] = now_dec.page;
        dec_word[bod_pkg::BOD_DEC_ABIT_LSB +: 3] = now_dec.acc_bit;
        dec_word[bod_pkg::BOD_DEC_TWO_BIT] = now_dec.two_byte;
        dec_word[bod_pkg::BOD_DEC_ROW_LSB +: 4] = opcode_r[7:4];
        dec_word[bod_pkg::BOD_DEC_COL_LSB +: 4] = opcode_r[3:0];
    end

    ////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle per access
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            waitrequest_r <= 1'b1;
        end else begin
            waitrequest_r <= !req_take;
        end
    end

    // Read data captured so it stands when waitrequest drops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            readdata_r <= '0;
        end else if (read && waitrequest_r) begin
            case (address)
                bod_pkg::BOD_OFF_INSTR: readdata_r <= {16'h0000, operand_r, opcode_r};
                bod_pkg::BOD_OFF_DECODE: readdata_r <= dec_word;
                bod_pkg::BOD_OFF_PC: readdata_r <= {20'h00000, pc_r};
                bod_pkg::BOD_OFF_SP: readdata_r <= {29'h00000000, stack_pointer_r};
                bod_pkg::BOD_OFF_PSW: readdata_r <= {24'h000000, program_status_word_r};
                bod_pkg::BOD_OFF_MBF: readdata_r <= {31'h00000000, memory_bank_flag_r};
                default: readdata_r <= 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Instruction register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            opcode_r <= bod_pkg::BOD_OPCODE_RST;
            operand_r <= 8'h00;
        end else if (wr_go && address == bod_pkg::BOD_OFF_INSTR) begin
            if (byteenable[0]) opcode_r <= writedata[7:0];
            if (byteenable[1]) operand_r <= writedata[15:8];
        end
    end

    // Program counter: software writes, jumps, calls and returns
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pc_r <= bod_pkg::BOD_PC_RST;
        end else if (do_call || do_jump) begin
            // Bit 11 comes from the bank flag, not the opcode
            pc_r <= {memory_bank_flag_r, exe_dec.page, writedata[15:8]};
        end else if (do_ret || do_return_restore_status) begin
            pc_r <= stk.rd_data[11:0];
        end else if (wr_go && address == bod_pkg::BOD_OFF_PC) begin
            if (byteenable[0]) pc_r[7:0] <= writedata[7:0];
            if (byteenable[1]) pc_r[11:8] <= writedata[11:8];
        end
    end

    // Stack pointer wraps within eight levels
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stack_pointer_r <= bod_pkg::BOD_SP_RST;
        end else if (do_call) begin
            stack_pointer_r <= stack_pointer_r + 3'h1;
        end else if (do_ret || do_return_restore_status) begin
            stack_pointer_r <= sp_dec;
        end else if (wr_go && address == bod_pkg::BOD_OFF_SP && byteenable[0]) begin
            stack_pointer_r <= writedata[2:0];
        end
    end

    // Status word: a plain return leaves it alone
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            program_status_word_r <= bod_pkg::BOD_PSW_RST;
        end else if (do_return_restore_status) begin
            program_status_word_r[7:bod_pkg::BOD_PSW_UP_LSB] <=
                stk.rd_data[bod_pkg::BOD_STACK_W-1 -: 4];
        end else if (exe_instr && exe_dec.op_class == bod_pkg::BOD_SELECT_REGISTER_BANK_ZERO) begin
            program_status_word_r[bod_pkg::BOD_PSW_UP_LSB] <= 1'b0;
        end else if (wr_go && address == bod_pkg::BOD_OFF_PSW && byteenable[0]) begin
            program_status_word_r <= writedata[7:0];
        end
    end

    // Memory bank flag, steers bit 11 of call and jump targets
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            memory_bank_flag_r <= 1'b0;
        end else if (wr_go && address == bod_pkg::BOD_OFF_MBF && byteenable[0]) begin
            memory_bank_flag_r <= writedata[0];
        end
    end

    assign readdata = readdata_r;
    assign waitrequest = waitrequest_r;

endmodule
`default_nettype wire

//--- bod_decoder_assertions.sv
// Purpose: Bus handshake and decode field checks for the opcode decoder
// Assumes: Opcode stored by a completed lane 0 write at offset 0
// Notes: Field checks fire only on a completed decode read
`timescale 1ns/1ps
`default_nettype none
module bod_decoder_assertions (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest
);
    logic [7:0] op_r;
    logic ins_wr;
    logic dec_rd;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Completed accesses seen on the bus
    assign ins_wr = write && !waitrequest && byteenable[0] && (address == bod_pkg::BOD_OFF_INSTR);
    assign dec_rd = read && !waitrequest && (address == bod_pkg::BOD_OFF_DECODE);
    // Shadow of the stored opcode, kept from the bus alone
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            op_r <= 8'h00;
        end else if (ins_wr) begin
            op_r <= writedata[7:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    property p_wait_one; (read || write) && waitrequest |=> !waitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("access not answered next cycle");
    property p_wait_pulse; $fell(waitrequest) |=> waitrequest; endproperty
    a_wait_pulse: assert property (p_wait_pulse) else $error("answer held too long");
    property p_idle; !read && !write && waitrequest |=> waitrequest; endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_row_col; dec_rd |-> readdata[27:20] == {op_r[3:0], op_r[7:4]}; endproperty
    a_row_col: assert property (p_row_col) else $error("row or column wrong");
    property p_page; dec_rd |-> readdata[15:13] == op_r[7:5]; endproperty
    a_page: assert property (p_page) else $error("page field wrong");
    property p_abit; dec_rd |-> readdata[18:16] == op_r[7:5]; endproperty
    a_abit: assert property (p_abit) else $error("accumulator bit wrong");
    property p_ptr; dec_rd |-> readdata[9] == op_r[0]; endproperty
    a_ptr: assert property (p_ptr) else $error("pointer select wrong");
    property p_port; dec_rd |-> readdata[12:10] == {1'b1, op_r[1:0]}; endproperty
    a_port: assert property (p_port) else $error("expander port wrong");
    property p_inc;
        dec_rd && op_r[7:3] == 5'h03 |-> readdata[8:0] == {op_r[2:0], bod_pkg::BOD_REG_INC};
    endproperty
    a_inc: assert property (p_inc) else $error("increment decode wrong");
endmodule
bind bod_decoder bod_decoder_assertions bod_decoder_assertions_i (
    .clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest));
`default_nettype wire

//--- bod_pkg.sv
// Purpose: Shared constants and types for the byte opcode decoder
// Assumes: Avalon-MM byte addresses, one 32-bit word per register
// Notes: Class codes are read back through the decode result register
package bod_pkg;

    // Register byte offsets
    localparam logic [4:0] BOD_OFF_INSTR = 5'h00;
    localparam logic [4:0] BOD_OFF_DECODE = 5'h04;
    localparam logic [4:0] BOD_OFF_PC = 5'h08;
    localparam logic [4:0] BOD_OFF_SP = 5'h0C;
    localparam logic [4:0] BOD_OFF_PSW = 5'h10;
    localparam logic [4:0] BOD_OFF_MBF = 5'h14;

    // Decode result field positions
    localparam int BOD_DEC_CLASS_LSB = 0;
    localparam int BOD_DEC_REG_LSB = 6;
    localparam int BOD_DEC_PTR_BIT = 9;
    localparam int BOD_DEC_PORT_LSB = 10;
    localparam int BOD_DEC_PAGE_LSB = 13;
    localparam int BOD_DEC_ABIT_LSB = 16;
    localparam int BOD_DEC_TWO_BIT = 19;
    localparam int BOD_DEC_ROW_LSB = 20;
    localparam int BOD_DEC_COL_LSB = 24;

    // Reset values
    localparam logic [11:0] BOD_PC_RST = 12'h000;
    localparam logic [2:0] BOD_SP_RST = 3'h0;
    localparam logic [7:0] BOD_PSW_RST = 8'h00;
    localparam logic [7:0] BOD_OPCODE_RST = 8'h00;

    // Stack geometry: {psw[7:4], bank flag, pc[11:0]}
    localparam int BOD_STACK_DEPTH = 8;
    localparam int BOD_STACK_W = 17;
    localparam int BOD_PSW_UP_LSB = 4;
    localparam int BOD_PC_LO_BYTE = 8;
    localparam int BOD_PC_HI_W = 4;
    localparam logic [3:0] BOD_EXP_PORT_BASE = 4'h4;

    typedef logic [BOD_STACK_W-1:0] bod_entry_t;

    typedef enum logic [5:0] {
        BOD_NOP, BOD_HALT, BOD_STOP, BOD_BLANK, BOD_OTHER,
        BOD_REG_INC, BOD_REG_DEC, BOD_REG_XCH, BOD_REG_OR, BOD_REG_AND,
        BOD_REG_XOR, BOD_REG_ADD, BOD_REG_ADD_WITH_CARRY, BOD_REG_FROM_ACC,
        BOD_REG_LOAD_IMM, BOD_REG_TO_ACC, BOD_DECREMENT_BRANCH_NONZERO,
        BOD_EXP_READ, BOD_EXP_WRITE, BOD_EXP_OR, BOD_EXP_AND,
        BOD_JUMP, BOD_CALL, BOD_ACC_BIT_BRANCH, BOD_SELECT_REGISTER_BANK_ZERO,
        BOD_ACC_ZERO_BRANCH, BOD_TIMER_READ, BOD_TIMER_LOAD,
        BOD_EVENT_COUNT_START, BOD_TIMER_RUN_START, BOD_TIMER_HALT,
        BOD_T0_CLOCK_EN, BOD_PAGE_TABLE_READ, BOD_PAGE3_TABLE_READ,
        BOD_INDIRECT_JUMP, BOD_RETURN, BOD_RETURN_RESTORE,
        BOD_INT_LOW_BRANCH, BOD_EXT_READ, BOD_EXT_WRITE, BOD_IND_INC,
        BOD_ACC_DEC, BOD_ACC_INC, BOD_ACC_CLR, BOD_ACC_CPL, BOD_ACC_SWAP,
        BOD_ACC_DA, BOD_ACC_RRC, BOD_ACC_RR, BOD_ACC_RL, BOD_ACC_RLC,
        BOD_BUS_STROBE_IN, BOD_P1_IN, BOD_P2_IN, BOD_BUS_OUT,
        BOD_P1_OUT, BOD_P2_OUT
    } bod_class_e;

    typedef struct packed {
        bod_class_e op_class;
        logic [2:0] working_register_index;
        logic pointer_sel;
        logic [2:0] expander_port_select;
        logic [2:0] page;
        logic [2:0] acc_bit;
        logic two_byte;
    } bod_dec_s;

endpackage

//--- bod_prog_mem.sv
// Purpose: Program memory model that hands opcode bytes to the bench
// Assumes: One byte per address, read without delay
// Notes: Image holds every code once so a walk covers the whole map
`timescale 1ns/1ps
`default_nettype none
module bod_prog_mem (
    input wire logic [7:0] fetch_addr,
    output logic [7:0] fetch_byte
);
    // Byte equals its address; a real image would hold a program
    assign fetch_byte = fetch_addr;
endmodule
`default_nettype wire

//--- bod_stack.sv
// Purpose: Eight-entry return stack held in flip-flops
// Assumes: Index wraps within three bits
// Notes: Entries are cleared at reset for a deterministic peek
`timescale 1ns/1ps
`default_nettype none
module bod_stack (
    input wire logic clock,
    input wire logic rst_n,
    bod_stack_if.store stk
);

    bod_pkg::bod_entry_t mem_r [bod_pkg::BOD_STACK_DEPTH];

    ////////////////////////////////////////////////////////////////////
    // Storage, written only on a push
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < bod_pkg::BOD_STACK_DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else if (stk.push) begin
            mem_r[stk.wr_idx] <= stk.wr_data;
        end
    end

    // Peek port for returns
    assign stk.rd_data = mem_r[stk.rd_idx];

endmodule
`default_nettype wire

//--- bod_stack_if.sv
// Purpose: Carries push and peek traffic between decoder core and stack
// Assumes: One push per clock at most
// Notes: Read side is combinational from the stored entries
`timescale 1ns/1ps
`default_nettype none
interface bod_stack_if;
    logic push;
    logic [2:0] wr_idx;
    bod_pkg::bod_entry_t wr_data;
    logic [2:0] rd_idx;
    bod_pkg::bod_entry_t rd_data;

    modport core (output push, output wr_idx, output wr_data, output rd_idx, input rd_data);
    modport store (input push, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface
`default_nettype wire

//--- byte_opcode_decoder_tb_top.sv
// Purpose: Self-checking bench for the opcode decoder
// Assumes: Bus answers within a bounded number of cycles
// Notes: Stack and class expectations come from a behavioural model
`timescale 1ns/1ps
`default_nettype none
module byte_opcode_decoder_tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] writedata = 32'h00000000;
    logic [31:0] readdata;
    logic waitrequest;
    logic [7:0] fetch_addr = 8'h00;
    logic [7:0] fetch_byte;
    logic [31:0] seed = 32'h9713592C;
    logic [31:0] q;
    int miscompares = 0;
    int compares = 0;
    // Clock at 100 MHz
    always #5 clock = ~clock;
    bod_decoder bod_decoder_i (.clock(clock), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest));
    bod_prog_mem bod_prog_mem_i (.fetch_addr(fetch_addr), .fetch_byte(fetch_byte));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One bus access; request held until waitrequest is sampled low
    task automatic bus(input bit wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        // Look at waitrequest mid-cycle, where it is settled, then act on the next rising edge
        do begin
            @(negedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 40);
        @(posedge clock);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 40) miscompares++;
    endtask
    // Expected class, or -1 where the map leaves it open
    function automatic int exp_class(input int op);
        int rg[12] = '{8'h18, 8'hC8, 8'h28, 8'h48, 8'h58, 8'hD8, 8'h68, 8'h78, 8'hA8, 8'hB8,
            8'hF8, 8'hE8};
        int ex[4] = '{8'h0C, 8'h3C, 8'h8C, 8'h9C};
        int fr[4] = '{8'h00, 8'h01, 8'hC1, 8'h22};
        int on[33] = '{8'hC5, 8'hC6, 8'h42, 8'h62, 8'h45, 8'h55, 8'h65, 8'h75, 8'hA3, 8'hE3,
            8'hB3, 8'h83, 8'h93, 8'h86, 8'h80, 8'h90, 8'h10, 8'h07, 8'h17, 8'h27, 8'h37, 8'h47,
            8'h57, 8'h67, 8'h77, 8'hE7, 8'hF7, 8'h08, 8'h09, 8'h0A, 8'h02, 8'h39, 8'h3A};
        if (op % 16 == 4) return int'(bod_pkg::BOD_JUMP) + (op / 16) % 2;
        if (op % 16 == 2 && (op / 16) % 2 == 1) return int'(bod_pkg::BOD_ACC_BIT_BRANCH);
        for (int k = 0; k < 12; k++) if (op / 8 == rg[k] / 8) return int'(bod_pkg::BOD_REG_INC) + k;
        for (int k = 0; k < 4; k++) if (op / 4 == ex[k] / 4) return int'(bod_pkg::BOD_EXP_READ) + k;
        for (int k = 0; k < 4; k++) if (op == fr[k]) return k;
        for (int k = 0; k < 33; k++) begin
            if (op == on[k] || (on[k] % 16 == 0 && op == on[k] + 1)) begin
                return int'(bod_pkg::BOD_SELECT_REGISTER_BANK_ZERO) + k;
            end
        end
        return -1;
    endfunction
    task automatic tally_and_finish;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int op, pc, sp, program_status_word, memory_bank_flag, opnd;
        bit [16:0] e;
        bit [16:0] stk[$];
        int flow[8] = '{8'h54, 8'h83, 8'hF4, 8'hC5, 8'h93, 8'hE4, 8'h14, 8'h93};
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        // Reset values, then an unmapped place that reads zero
        for (int k = 0; k < 5; k++) begin
            bus(0, bod_pkg::BOD_OFF_PC + 5'(4 * k), 0);
            chk(q, 0);
        end
        bus(1, 5'h18, 32'hFFFFFFFF);
        bus(0, 5'h18, 0);
        chk(q, 0);
        $display("test reset_values done");
        // Every opcode from program memory, decoded and compared
        for (int k = 0; k < 256; k++) begin
            fetch_addr = 8'(k);
            #1;
            op = fetch_byte;
            seed = lfsr(seed);
            bus(1, bod_pkg::BOD_OFF_INSTR, {16'h0000, seed[7:0], 8'(op)});
            bus(0, bod_pkg::BOD_OFF_DECODE, 0);
            chk(q & 32'hFFF7FFC0, {4'h0, op[3:0], op[7:4], 1'b0, op[7:5], op[7:5], 1'b1,
                op[1:0], op[0], op[2:0], 6'h00});
            if (exp_class(op) >= 0) chk({26'h0, q[5:0]}, 32'(exp_class(op)));
            if (op % 16 == 4 || op / 8 == 8'h17 || op / 8 == 8'h1D) chk({31'h0, q[19]}, 32'h1);
        end
        // Lane 0 off: stored opcode FF stays
        byteenable <= 4'hE;
        bus(1, bod_pkg::BOD_OFF_INSTR, 0);
        byteenable <= 4'hF;
        bus(0, bod_pkg::BOD_OFF_DECODE, 0);
        chk({24'h0, q[27:20]}, 32'hFF);
        $display("test opcode_sweep done");
        // Calls, jumps and returns against a queue stack model
        bus(1, bod_pkg::BOD_OFF_SP, 0);
        sp = 0;
        for (int k = 0; k < 8; k++) begin
            seed = lfsr(seed);
            program_status_word = seed[7:0];
            pc = seed[19:8];
            memory_bank_flag = seed[20];
            opnd = seed[31:24];
            op = flow[k];
            bus(1, bod_pkg::BOD_OFF_PSW, program_status_word);
            bus(1, bod_pkg::BOD_OFF_PC, pc);
            bus(1, bod_pkg::BOD_OFF_MBF, memory_bank_flag);
            bus(1, bod_pkg::BOD_OFF_INSTR, {16'h0000, 8'(opnd), 8'(op)});
            if (op % 16 == 4) begin
                if ((op / 16) % 2 == 1) begin
                    stk.push_back({program_status_word[7:4], memory_bank_flag[0], pc[11:0]});
                    sp = (sp + 1) % 8;
                end
                pc = memory_bank_flag * 2048 + (op / 32) * 256 + opnd;
            end else if (op == 8'hC5) begin
                program_status_word = program_status_word & 8'hEF;
            end else begin
                e = stk.pop_back();
                sp = (sp + 7) % 8;
                pc = e[11:0];
                if (op == 8'h93) program_status_word = program_status_word % 16 + e[16:13] * 16;
            end
            bus(0, bod_pkg::BOD_OFF_PC, 0);
            chk(q, pc);
            bus(0, bod_pkg::BOD_OFF_SP, 0);
            chk(q, sp);
            bus(0, bod_pkg::BOD_OFF_PSW, 0);
            chk(q, program_status_word);
        end
        $display("test call_return done");
        tally_and_finish;
    end
    // Watchdog well beyond the expected run of about 1750 cycles
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
